// File: rtcc_defs.vh
// constants for the time, calendar and trim core
`ifndef RTCC_DEFS_VH
`define RTCC_DEFS_VH

// register addresses
`define RTCC_ADDR_SEC   4'h0
`define RTCC_ADDR_MIN   4'h1
`define RTCC_ADDR_HOUR  4'h2
`define RTCC_ADDR_WDAY  4'h3
`define RTCC_ADDR_MDAY  4'h4
`define RTCC_ADDR_MON   4'h5
`define RTCC_ADDR_YEAR  4'h6
`define RTCC_ADDR_TRIM  4'h7

// implemented-bit masks, unused high bits read 0
`define RTCC_MASK_SEC   8'h7f
`define RTCC_MASK_MIN   8'h7f
`define RTCC_MASK_HOUR  8'h3f
`define RTCC_MASK_WDAY  8'h07
`define RTCC_MASK_MDAY  8'h3f
`define RTCC_MASK_MON   8'h9f
`define RTCC_MASK_YEAR  8'hff
`define RTCC_MASK_TRIM  8'h7f

// field positions
`define RTCC_HOUR_PM_BIT    5
`define RTCC_MON_CENT_BIT   7
`define RTCC_TRIM_LOCK_BIT  7
`define RTCC_TRIM_DIR_BIT   6

// bcd limits and special codes
`define RTCC_BCD_ZERO     8'h00
`define RTCC_BCD_ONE      8'h01
`define RTCC_SEC_MAX      8'h59
`define RTCC_MIN_MAX      8'h59
`define RTCC_HR24_MAX     8'h23
`define RTCC_HR12_AM11    8'h11
`define RTCC_HR12_PM11    8'h31
`define RTCC_HR12_MIDN    8'h12
`define RTCC_HR12_NOON    8'h32
`define RTCC_HR12_AM1     8'h01
`define RTCC_HR12_PM1     8'h21
`define RTCC_WDAY_MAX     3'h6
`define RTCC_MON_MAX      8'h12
`define RTCC_YEAR_MAX     8'h99
`define RTCC_MON_FEB      8'h02
`define RTCC_MON_APR      8'h04
`define RTCC_MON_JUN      8'h06
`define RTCC_MON_SEP      8'h09
`define RTCC_MON_NOV      8'h11
`define RTCC_DAYS_31      8'h31
`define RTCC_DAYS_30      8'h30
`define RTCC_DAYS_29      8'h29
`define RTCC_DAYS_28      8'h28
`define RTCC_TRIM_PT0     8'h00
`define RTCC_TRIM_PT1     8'h20
`define RTCC_TRIM_PT2     8'h40

// crystal cycles per uncorrected second
`define RTCC_XTAL_PER_SEC 16'h8000

// reset values
`define RTCC_RST_HOUR     8'h00
`define RTCC_RST_MDAY     8'h01
`define RTCC_RST_MON      8'h01

`endif

// File: rtcc_core.v
// time, calendar and digital trim core of a real time clock
`timescale 1ns/1ps
`include "rtcc_defs.vh"
// Function
// RULE1: seconds BCD 00-59, wrap carries to minutes
// RULE2: minutes BCD 00-59, wrap carries to hours
// RULE3: hour wrap carries to weekday and monthday
// RULE4: seconds write clears sub-second prescaler
// RULE5: host writes only valid time values
// RULE6: time registers at 0-2, unused bits zero
// RULE7: weekday counts 0 to 6 then wraps
// RULE8: host avoids weekday code seven
// RULE9: monthday limit depends on month and leap
// RULE10: monthday wraps to 1, month 1-12 carries
// RULE11: years 00-99, divisible by four leap
// RULE12: century bit toggles on year wrap
// RULE13: host writes only valid calendar values
// RULE14: trim write needs top bit zero
// RULE15: trim applied only at 00,20,40 seconds
// RULE16: untrimmed second is 32768 crystal cycles
// RULE17: direction zero lengthens by (F-1)*2
// RULE18: direction one shortens by (~F+1)*2
// RULE19: zero upper trim bits means no trim
// RULE20: trim write suppresses coinciding trim, arms
// RULE21: trim changes count, never crystal frequency
// RULE22: oscillator halt clears trim register
// RULE23: twelve hour midnight 12, noon 32
// RULE24: whole carry ripples in one tick
// RULE25: writes accepted anytime, counting continues

module rtcc_core #(
  parameter [15:0] XTAL_PER_SEC = `RTCC_XTAL_PER_SEC
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       srst,
  // crystal clock and oscillator halt, asynchronous
  input  wire       xtal_clk,
  input  wire       osc_halt_flag,
  // hour mode, same clock domain
  input  wire       mode_24h,
  // register access
  input  wire       reg_wr_en,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wr_data,
  output reg  [7:0] reg_rd_data_q,
  // one pulse per counted second
  output reg        sec_tick_q
);

  // synchronisers
  reg        xtal_s1_q;
  reg        xtal_s2_q;
  reg        xtal_s3_q;
  reg        halt_s1_q;
  reg        halt_s2_q;

  // counters and trim state
  reg [7:0]  sec_q;
  reg [7:0]  min_q;
  reg [7:0]  hour_q;
  reg [2:0]  wday_q;
  reg [7:0]  mday_q;
  reg [7:0]  mon_q;
  reg [7:0]  year_q;
  reg [7:0]  trim_q;
  reg        trim_armed_q;
  reg        trim_apply_q;
  reg [15:0] pre_q;

  // next-value logic
  reg [7:0]  sec_d;
  reg [7:0]  min_d;
  reg [7:0]  hour_d;
  reg [2:0]  wday_d;
  reg [7:0]  mday_d;
  reg [7:0]  mon_d;
  reg [7:0]  year_d;
  reg        min_cy;
  reg        hour_cy;
  reg        day_cy;
  reg        mon_cy;
  reg        year_cy;
  reg        cent_d;
  reg [7:0]  last_day;
  reg        leap;
  reg [7:0]  rd_mux;

  wire       xtal_tick;
  wire       trim_nz;
  wire [15:0] inc_adj;
  wire [15:0] dec_adj;
  wire [15:0] sec_len;
  wire       pre_last;
  wire       sec_wrap;
  wire       wr_sec;
  wire       wr_trim;
  wire       trim_take;

  // bcd increment of a two-digit value
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // second points at which the trim may act
  function trim_point;
    input [7:0] s;
    begin
      trim_point = (s == `RTCC_TRIM_PT0) || (s == `RTCC_TRIM_PT1) || (s == `RTCC_TRIM_PT2); // RULE15
    end
  endfunction

  // crystal edge detect on synchronised copies only
  always @(posedge clk_sys) begin
    if (srst) begin
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      xtal_s3_q <= 1'b0;
      halt_s1_q <= 1'b0;
      halt_s2_q <= 1'b0;
    end else begin
      xtal_s1_q <= xtal_clk;
      xtal_s2_q <= xtal_s1_q;
      xtal_s3_q <= xtal_s2_q;
      halt_s1_q <= osc_halt_flag;
      halt_s2_q <= halt_s1_q;
    end
  end

  assign xtal_tick = xtal_s2_q & ~xtal_s3_q;

  // second length from the trim setting
  assign trim_nz  = |trim_q[5:1]; // RULE19
  assign inc_adj  = {9'h000, trim_q[5:0] - 6'h01, 1'b0}; // RULE17
  assign dec_adj  = {8'h00, {1'b0, ~trim_q[5:0]} + 7'h01, 1'b0}; // RULE18
  assign sec_len  = !trim_apply_q ? XTAL_PER_SEC : // RULE16
                    (trim_q[`RTCC_TRIM_DIR_BIT] ? XTAL_PER_SEC - dec_adj : XTAL_PER_SEC + inc_adj);
  // prescaler only counts crystal edges, the crystal itself is untouched
  assign pre_last = (pre_q == sec_len - 16'h0001); // RULE21
  assign sec_wrap = xtal_tick & pre_last;

  assign wr_sec    = reg_wr_en && (reg_addr == `RTCC_ADDR_SEC);
  assign wr_trim   = reg_wr_en && (reg_addr == `RTCC_ADDR_TRIM);
  assign trim_take = wr_trim && !reg_wr_data[`RTCC_TRIM_LOCK_BIT]; // RULE14

  // leap year and month length
  // leap: even tens with units 0/4/8, odd tens with units 2/6
  always @* begin
    leap = 1'b0;
    if (year_q[4] == 1'b0) begin
      leap = (year_q[3:0] == 4'h0) || (year_q[3:0] == 4'h4) || (year_q[3:0] == 4'h8); // RULE11
    end else begin
      leap = (year_q[3:0] == 4'h2) || (year_q[3:0] == 4'h6); // RULE11
    end
    case ({3'b000, mon_q[4:0]})
      `RTCC_MON_FEB: last_day = leap ? `RTCC_DAYS_29 : `RTCC_DAYS_28; // RULE9
      `RTCC_MON_APR,
      `RTCC_MON_JUN,
      `RTCC_MON_SEP,
      `RTCC_MON_NOV: last_day = `RTCC_DAYS_30; // RULE9
      default:       last_day = `RTCC_DAYS_31; // RULE9
    endcase
  end

  // full carry chain evaluated in one tick
  always @* begin
    // seconds
    min_cy = (sec_q == `RTCC_SEC_MAX);
    sec_d  = min_cy ? `RTCC_BCD_ZERO : bcd_inc(sec_q); // RULE1 RULE24
    // minutes
    hour_cy = min_cy && (min_q == `RTCC_MIN_MAX);
    min_d   = (min_q == `RTCC_MIN_MAX) ? `RTCC_BCD_ZERO : bcd_inc(min_q); // RULE2
    // hours
    day_cy = 1'b0;
    hour_d = hour_q;
    if (mode_24h) begin
      if (hour_q == `RTCC_HR24_MAX) begin
        hour_d = `RTCC_BCD_ZERO;
        day_cy = hour_cy; // RULE3
      end else begin
        hour_d = bcd_inc(hour_q);
      end
    end else begin
      // noon and midnight codes are special, pm flag carried otherwise
      case (hour_q)
        `RTCC_HR12_PM11: begin
          hour_d = `RTCC_HR12_MIDN; // RULE23
          day_cy = hour_cy; // RULE3
        end
        `RTCC_HR12_AM11: hour_d = `RTCC_HR12_NOON; // RULE23
        `RTCC_HR12_MIDN: hour_d = `RTCC_HR12_AM1;
        `RTCC_HR12_NOON: hour_d = `RTCC_HR12_PM1;
        default: begin
          hour_d = bcd_inc({3'b000, hour_q[4:0]});
          hour_d[`RTCC_HOUR_PM_BIT] = hour_q[`RTCC_HOUR_PM_BIT];
        end
      endcase
    end
    // weekday
    wday_d = (wday_q == `RTCC_WDAY_MAX) ? 3'h0 : wday_q + 3'h1; // RULE7
    // day of month
    mon_cy = day_cy && (mday_q == last_day);
    mday_d = (mday_q == last_day) ? `RTCC_BCD_ONE : bcd_inc(mday_q); // RULE10
    // month
    year_cy = mon_cy && ({3'b000, mon_q[4:0]} == `RTCC_MON_MAX);
    if ({3'b000, mon_q[4:0]} == `RTCC_MON_MAX) begin
      mon_d = `RTCC_BCD_ONE; // RULE10
    end else begin
      mon_d = bcd_inc({3'b000, mon_q[4:0]});
    end
    // year and century
    // century flips only on the december step out of year 99
    year_d = (year_q == `RTCC_YEAR_MAX) ? `RTCC_BCD_ZERO : bcd_inc(year_q); // RULE11
    cent_d = mon_q[`RTCC_MON_CENT_BIT] ^ (year_cy && (year_q == `RTCC_YEAR_MAX)); // RULE12
    mon_d[`RTCC_MON_CENT_BIT] = cent_d;
  end

  // counters: a host write wins over a carry for the written register
  always @(posedge clk_sys) begin
    if (srst) begin
      sec_q  <= `RTCC_BCD_ZERO;
      min_q  <= `RTCC_BCD_ZERO;
      hour_q <= `RTCC_RST_HOUR;
      wday_q <= 3'h0;
      mday_q <= `RTCC_RST_MDAY;
      mon_q  <= `RTCC_RST_MON;
      year_q <= `RTCC_BCD_ZERO;
    end else begin
      if (wr_sec) begin
        sec_q <= reg_wr_data & `RTCC_MASK_SEC; // RULE25
      end else if (sec_wrap) begin
        sec_q <= sec_d; // RULE1
      end
      if (reg_wr_en && (reg_addr == `RTCC_ADDR_MIN)) begin
        min_q <= reg_wr_data & `RTCC_MASK_MIN; // RULE25
      end else if (sec_wrap && min_cy) begin
        min_q <= min_d; // RULE1
      end
      if (reg_wr_en && (reg_addr == `RTCC_ADDR_HOUR)) begin
        hour_q <= reg_wr_data & `RTCC_MASK_HOUR; // RULE25
      end else if (sec_wrap && hour_cy) begin
        hour_q <= hour_d; // RULE2
      end
      if (reg_wr_en && (reg_addr == `RTCC_ADDR_WDAY)) begin
        wday_q <= reg_wr_data[2:0]; // RULE25
      end else if (sec_wrap && day_cy) begin
        wday_q <= wday_d; // RULE3
      end
      if (reg_wr_en && (reg_addr == `RTCC_ADDR_MDAY)) begin
        mday_q <= reg_wr_data & `RTCC_MASK_MDAY; // RULE25
      end else if (sec_wrap && day_cy) begin
        mday_q <= mday_d; // RULE3
      end
      if (reg_wr_en && (reg_addr == `RTCC_ADDR_MON)) begin
        mon_q <= reg_wr_data & `RTCC_MASK_MON; // RULE25
      end else if (sec_wrap && mon_cy) begin
        mon_q <= mon_d; // RULE10
      end else if (sec_wrap && year_cy) begin
        mon_q <= mon_d; // RULE12
      end
      if (reg_wr_en && (reg_addr == `RTCC_ADDR_YEAR)) begin
        year_q <= reg_wr_data & `RTCC_MASK_YEAR; // RULE25
      end else if (sec_wrap && year_cy) begin
        year_q <= year_d; // RULE10
      end
    end
  end

  // prescaler and second pulse
  always @(posedge clk_sys) begin
    if (srst) begin
      pre_q      <= 16'h0000;
      sec_tick_q <= 1'b0;
    end else begin
      // no pulse when a seconds write restarts the second
      sec_tick_q <= sec_wrap & ~wr_sec;
      if (wr_sec) begin
        pre_q <= 16'h0000; // RULE4
      end else if (sec_wrap) begin
        pre_q <= 16'h0000; // RULE16
      end else if (xtal_tick) begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end

  // trim register, arming and per-second apply decision
  // a held halt keeps the trim cleared and disarmed
  always @(posedge clk_sys) begin
    if (srst) begin
      trim_q       <= 8'h00;
      trim_armed_q <= 1'b0;
      trim_apply_q <= 1'b0;
    end else if (halt_s2_q) begin
      trim_q       <= 8'h00; // RULE22
      trim_armed_q <= 1'b0;
      trim_apply_q <= 1'b0;
    end else begin
      if (trim_take) begin
        trim_q       <= reg_wr_data & `RTCC_MASK_TRIM; // RULE14
        trim_armed_q <= 1'b1; // RULE20
      end
      if (wr_trim) begin
        trim_apply_q <= 1'b0; // RULE20
      end else if (wr_sec) begin
        trim_apply_q <= trim_armed_q && trim_nz && trim_point(reg_wr_data & `RTCC_MASK_SEC); // RULE15
      end else if (sec_wrap) begin
        trim_apply_q <= trim_armed_q && trim_nz && trim_point(sec_d); // RULE15 RULE19
      end
    end
  end

  // read mux, registered
  always @* begin
    case (reg_addr)
      `RTCC_ADDR_SEC:  rd_mux = sec_q & `RTCC_MASK_SEC; // RULE6
      `RTCC_ADDR_MIN:  rd_mux = min_q & `RTCC_MASK_MIN; // RULE6
      `RTCC_ADDR_HOUR: rd_mux = hour_q & `RTCC_MASK_HOUR; // RULE6
      `RTCC_ADDR_WDAY: rd_mux = {5'h00, wday_q};
      `RTCC_ADDR_MDAY: rd_mux = mday_q & `RTCC_MASK_MDAY;
      `RTCC_ADDR_MON:  rd_mux = mon_q & `RTCC_MASK_MON;
      `RTCC_ADDR_YEAR: rd_mux = year_q;
      `RTCC_ADDR_TRIM: rd_mux = trim_q & `RTCC_MASK_TRIM;
      default:         rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rd_data_q <= 8'h00;
    end else begin
      reg_rd_data_q <= rd_mux;
    end
  end

endmodule

// File: rtcc_xtal_model.sv
// crystal source and halt detector model facing the core
`timescale 1ns/1ps
module rtcc_xtal_model #(
  parameter int HALF_NS = 40
) (
  // halt request from the bench
  input  wire  halt_req,
  // crystal side
  output logic xtal_clk,
  output logic osc_halt_flag
);
  initial xtal_clk = 1'b0;
  // free-running, never retuned by the trim
  always #(HALF_NS) xtal_clk = ~xtal_clk;
  assign osc_halt_flag = halt_req;
endmodule

// File: rtcc_core_assertions.sv
// assertion checker for the time, calendar and trim core
`timescale 1ns/1ps
module rtcc_core_assertions #(
  parameter [15:0] XTAL_PER_SEC = 16'h8000
) (
  // clock and reset
  input wire       clk_sys,
  input wire       srst,
  // crystal side and hour mode
  input wire       xtal_clk,
  input wire       osc_halt_flag,
  input wire       mode_24h,
  // register access and second pulse
  input wire       reg_wr_en,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire [7:0] reg_rd_data_q,
  input wire       sec_tick_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_unmapped_reads_zero: assert property (reg_addr[3] |=> reg_rd_data_q == 8'h00)
    else $error("unmapped read not zero");
  a_seconds_bcd: assert property (reg_addr == 4'h0 |=> reg_rd_data_q[7:4] <= 4'h5
    && reg_rd_data_q[3:0] <= 4'h9)
    else $error("seconds out of range");
  a_minutes_bcd: assert property (reg_addr == 4'h1 |=> reg_rd_data_q[7:4] <= 4'h5
    && reg_rd_data_q[3:0] <= 4'h9)
    else $error("minutes out of range");
  a_hour_high_zero: assert property (reg_addr == 4'h2 |=> reg_rd_data_q[7:6] == 2'b00)
    else $error("hour high bits set");
  a_weekday_range: assert property (reg_addr == 4'h3 |=> reg_rd_data_q <= 8'h06)
    else $error("weekday out of range");
  a_monthday_range: assert property (reg_addr == 4'h4 |=> reg_rd_data_q != 8'h00 && reg_rd_data_q <= 8'h31)
    else $error("monthday out of range");
  a_month_range: assert property (reg_addr == 4'h5 |=> reg_rd_data_q[4:0] != 5'h00
    && reg_rd_data_q[6:0] <= 7'h12)
    else $error("month out of range");
  a_trim_top_zero: assert property (reg_addr == 4'h7 |=> !reg_rd_data_q[7])
    else $error("trim top bit set");
  a_trim_halt_clear: assert property (osc_halt_flag [*5] ##0 reg_addr == 4'h7 |=> reg_rd_data_q == 8'h00)
    else $error("trim not cleared by halt");
  a_trim_write_back: assert property (!osc_halt_flag [*4] ##0 (reg_wr_en && reg_addr == 4'h7
    && !reg_wr_data[7]) ##1 reg_addr == 4'h7 |=> reg_rd_data_q == ($past(reg_wr_data, 2) & 8'h7f))
    else $error("trim write lost");
  a_tick_one_cycle: assert property (sec_tick_q |=> !sec_tick_q [*8])
    else $error("tick too wide");
  c_tick: cover property (sec_tick_q);
  c_trim_write: cover property (reg_wr_en && reg_addr == 4'h7);
  c_halt_read: cover property (osc_halt_flag && reg_addr == 4'h7);
endmodule

bind rtcc_core rtcc_core_assertions #(.XTAL_PER_SEC(XTAL_PER_SEC)) u_chk (.clk_sys(clk_sys), .srst(srst),
  .xtal_clk(xtal_clk), .osc_halt_flag(osc_halt_flag), .mode_24h(mode_24h), .reg_wr_en(reg_wr_en),
  .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data_q(reg_rd_data_q), .sec_tick_q(sec_tick_q));

// File: rtcc_core_tb.sv
// self-checking bench for the time, calendar and trim core
`timescale 1ns/1ps
module rtcc_core_tb;
  reg        clk_sys = 1'b0;
  reg        srst = 1'b1;
  reg        halt_req = 1'b0;
  reg        mode_24h = 1'b1;
  reg        reg_wr_en = 1'b0;
  reg  [3:0] reg_addr = 4'h0;
  reg  [7:0] reg_wr_data = 8'h00;
  wire [7:0] reg_rd_data_q;
  wire       sec_tick_q;
  wire       xtal_clk;
  wire       osc_halt_flag;
  reg  [7:0] wv [0:6];
  int        mismatches = 0;
  int        checks_done = 0;
  int        cyc = 0;
  int        n;

  always #5 clk_sys = ~clk_sys;

  rtcc_xtal_model #(.HALF_NS(40)) u_xtal (.halt_req(halt_req), .xtal_clk(xtal_clk), .osc_halt_flag(osc_halt_flag));
  rtcc_core #(.XTAL_PER_SEC(16'h0100)) u_dut (.clk_sys(clk_sys), .srst(srst), .xtal_clk(xtal_clk),
    .osc_halt_flag(osc_halt_flag), .mode_24h(mode_24h), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data_q(reg_rd_data_q), .sec_tick_q(sec_tick_q));

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      end_sim;
    end
  end

  task chk(input string nm, input [11:0] e, input [11:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task wr(input [3:0] a, input [7:0] v);
    @(posedge clk_sys) #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = v;
    @(posedge clk_sys) #1;
    reg_wr_en = 1'b0;
  endtask

  task rdc(input [3:0] a, input [7:0] e);
    @(posedge clk_sys) #1;
    reg_addr = a;
    @(posedge clk_sys) #1;
    chk($sformatf("register %0h", a), {4'h0, e}, {4'h0, reg_rd_data_q});
  endtask

  // cycles up to the next one-second pulse
  task wt;
    n = 0;
    do begin
      @(posedge clk_sys) #1;
      n++;
    end while (sec_tick_q !== 1'b1 && n < 4000);
    if (n >= 4000) chk("tick wait", 12'h000, 12'h001);
  endtask

  // load a date at 59 s past 59 min, check it one second later
  task cal(input m, input [7:0] h, w, md, mo, y, eh, ew, emd, emo, ey);
    @(posedge clk_sys) #1 mode_24h = m;
    wv = '{8'h59, 8'h59, h, w, md, mo, y};
    for (int i = 6; i >= 0; i--) wr(i[3:0], wv[i]);
    wt;
    wv = '{8'h00, 8'h00, eh, ew, emd, emo, ey};
    for (int i = 0; i < 7; i++) rdc(i[3:0], wv[i]);
  endtask

  // length in clocks of the second after seconds reach s+1
  task trm(input [7:0] t, input [7:0] s, input rw, input [11:0] e);
    wr(4'h7, t);
    wr(4'h0, s);
    wt;
    if (rw) wr(4'h7, t);
    wt;
    chk("second length", e, n[11:0] + (rw ? 12'd2 : 12'd0));
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    #1 srst = 1'b0;
    for (int i = 0; i < 8; i++) rdc(i[3:0], (i == 4 || i == 5) ? 8'h01 : 8'h00);
    wr(4'h9, 8'h55);
    rdc(4'h9, 8'h00);
    $display("test reset done");
    // valid values only
    cal(1, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99, 8'h00, 8'h00, 8'h01, 8'h81, 8'h00);
    cal(1, 8'h23, 8'h02, 8'h28, 8'h02, 8'h01, 8'h00, 8'h03, 8'h01, 8'h03, 8'h01);
    cal(1, 8'h23, 8'h04, 8'h28, 8'h02, 8'h96, 8'h00, 8'h05, 8'h29, 8'h02, 8'h96);
    cal(1, 8'h23, 8'h01, 8'h28, 8'h02, 8'h18, 8'h00, 8'h02, 8'h01, 8'h03, 8'h18);
    cal(1, 8'h23, 8'h02, 8'h28, 8'h02, 8'h04, 8'h00, 8'h03, 8'h29, 8'h02, 8'h04);
    cal(1, 8'h23, 8'h00, 8'h29, 8'h02, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h00);
    cal(1, 8'h23, 8'h00, 8'h30, 8'h04, 8'h10, 8'h00, 8'h01, 8'h01, 8'h05, 8'h10);
    cal(1, 8'h23, 8'h00, 8'h30, 8'h01, 8'h10, 8'h00, 8'h01, 8'h31, 8'h01, 8'h10);
    cal(1, 8'h23, 8'h05, 8'h31, 8'h92, 8'h99, 8'h00, 8'h06, 8'h01, 8'h01, 8'h00);
    cal(1, 8'h09, 8'h03, 8'h09, 8'h05, 8'h19, 8'h10, 8'h03, 8'h09, 8'h05, 8'h19);
    cal(0, 8'h11, 8'h01, 8'h15, 8'h06, 8'h10, 8'h32, 8'h01, 8'h15, 8'h06, 8'h10);
    cal(0, 8'h31, 8'h01, 8'h15, 8'h06, 8'h10, 8'h12, 8'h02, 8'h16, 8'h06, 8'h10);
    cal(0, 8'h12, 8'h01, 8'h15, 8'h06, 8'h10, 8'h01, 8'h01, 8'h15, 8'h06, 8'h10);
    cal(0, 8'h32, 8'h01, 8'h15, 8'h06, 8'h10, 8'h21, 8'h01, 8'h15, 8'h06, 8'h10);
    $display("test calendar done");
    trm(8'h07, 8'h59, 1'b0, 12'd2144);
    trm(8'h7e, 8'h19, 1'b0, 12'd2016);
    trm(8'h42, 8'h39, 1'b0, 12'd1056);
    trm(8'h41, 8'h59, 1'b0, 12'd2048);
    trm(8'h07, 8'h05, 1'b0, 12'd2048);
    trm(8'h07, 8'h59, 1'b1, 12'd2048);
    wr(4'h7, 8'h87);
    rdc(4'h7, 8'h07);
    $display("test trim done");
    repeat (700) @(posedge clk_sys);
    wr(4'h0, 8'h10);
    wt;
    chk("restarted second", 12'h001, {11'h000, n >= 2030 && n <= 2070});
    rdc(4'h0, 8'h11);
    @(posedge clk_sys) #1 halt_req = 1'b1;
    repeat (6) @(posedge clk_sys);
    rdc(4'h7, 8'h00);
    wr(4'h7, 8'h05);
    rdc(4'h7, 8'h00);
    @(posedge clk_sys) #1 halt_req = 1'b0;
    repeat (4) @(posedge clk_sys);
    wr(4'h7, 8'h05);
    rdc(4'h7, 8'h05);
    $display("test halt done");
    end_sim;
  end
endmodule
